// ### common/ddsf_consts.vh
// constants for the two-die serial flash command router
`ifndef DDSF_CONSTS_VH
`define DDSF_CONSTS_VH
// opcodes
`define DDSF_OP_WRITE_LATCH_SET_CMD 8'h06
`define DDSF_OP_WRDI 8'h04
`define DDSF_OP_WIDE 8'hB7
`define DDSF_OP_READ3 8'h03
`define DDSF_OP_READ4 8'h13
`define DDSF_OP_PP3 8'h02
`define DDSF_OP_PP4 8'h12
`define DDSF_OP_SE3 8'hD8
`define DDSF_OP_SE4 8'hDC
`define DDSF_OP_RREAD 8'h65
`define DDSF_OP_RWRITE 8'h71
`define DDSF_OP_U01 8'h01
`define DDSF_OP_U35 8'h35
`define DDSF_OP_U05 8'h05
`define DDSF_OP_U07 8'h07
`define DDSF_OP_U43 8'h43
`define DDSF_OP_U2F 8'h2F
`define DDSF_OP_UE8 8'hE8
`define DDSF_OP_UE4 8'hE4
`define DDSF_OP_UB0 8'hB0
`define DDSF_OP_U30 8'h30
// die layout
`define DDSF_DIE_BIT 26
`define DDSF_ERASED 8'hFF
// delivery values
`define DDSF_RST_STATUS 8'h00
`define DDSF_RST_CFG1 8'h00
`define DDSF_RST_CFG2 8'h08
`define DDSF_RST_CFG3 8'h00
`define DDSF_RST_CFG4 8'h00
`define DDSF_RST_PROT 16'hFFFF
// register indices inside a die (low address bits of 65h/71h)
`define DDSF_RIDX_STATUS 3'h0
`define DDSF_RIDX_CFG1 3'h2
`define DDSF_RIDX_CFG2 3'h3
`define DDSF_RIDX_CFG3 3'h4
`define DDSF_RIDX_CFG4 3'h5
// field positions
`define DDSF_BP_HI 4
`define DDSF_BP_LO 2
`define DDSF_ORIENT_BIT 5
`define DDSF_PROT_BASE 19
// uniform sector map region word: size 07FFFFh, erase byte F4h
`define DDSF_MAP_WORD 32'h07FFFFF4
// bus map
`define DDSF_A_CTRL 8'h00
`define DDSF_A_STATUS 8'h04
`define DDSF_A_COUNT 8'h08
`define DDSF_A_PTR 8'h0C
`define DDSF_A_MAP 8'h10
`define DDSF_A_PROT 8'h14
`define DDSF_A_DIE0 8'h18
`define DDSF_A_DIE1 8'h1C
`define DDSF_A_CFG4 8'h20
`define DDSF_RESP_OK 2'b00
`define DDSF_RESP_ERR 2'b10
`endif

// ### hdl/ddsf_die.v
// one die: its registers, write latch and range protection check
`timescale 1ns/100ps
`include "ddsf_consts.vh"
module ddsf_die (
  // clock, reset, enable
  input wire aclk,
  input wire aresetn,
  input wire ce,
  // control strobes
  input wire latch_set,
  input wire latch_clr_all,
  input wire write_done,
  input wire reg_wr,
  input wire [2:0] reg_idx,
  input wire [7:0] reg_wdata,
  input wire [25:0] offset,
  // state out
  output wire latch,
  output wire prot,
  output reg [7:0] reg_rdata,
  output wire [7:0] status_q_out,
  output wire [7:0] cfg1_out,
  output wire [7:0] cfg2_out,
  output wire [7:0] cfg3_out,
  output wire [7:0] cfg4_out
);
  reg latch_q;
  reg [7:0] status_q;
  reg [7:0] cfg1_q;
  reg [7:0] cfg2_q;
  reg [7:0] cfg3_q;
  reg [7:0] cfg4_q;
  wire [2:0] bp;
  wire [25:0] mask;
  wire [4:0] shamt;

  // latch set by the shared enable; the shared disable or own completed write clears it
  always @(posedge aclk) begin
    if (!aresetn) begin
      latch_q <= 1'b0;
    end else if (ce) begin
      if (latch_set) begin
        latch_q <= 1'b1;
      end else if (latch_clr_all || write_done) begin
        latch_q <= 1'b0;
      end
    end
  end

  // registers come up at delivery values
  always @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= `DDSF_RST_STATUS;
      cfg1_q <= `DDSF_RST_CFG1;
      cfg2_q <= `DDSF_RST_CFG2;
      cfg3_q <= `DDSF_RST_CFG3;
      cfg4_q <= `DDSF_RST_CFG4;
    end else if (ce && reg_wr) begin
      case (reg_idx)
        `DDSF_RIDX_STATUS: status_q <= reg_wdata;
        `DDSF_RIDX_CFG1: cfg1_q <= reg_wdata;
        `DDSF_RIDX_CFG2: cfg2_q <= reg_wdata;
        `DDSF_RIDX_CFG3: cfg3_q <= reg_wdata;
        `DDSF_RIDX_CFG4: cfg4_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // register readback; unknown index reads erased value
  always @* begin
    case (reg_idx)
      `DDSF_RIDX_STATUS: reg_rdata = status_q;
      `DDSF_RIDX_CFG1: reg_rdata = cfg1_q;
      `DDSF_RIDX_CFG2: reg_rdata = cfg2_q;
      `DDSF_RIDX_CFG3: reg_rdata = cfg3_q;
      `DDSF_RIDX_CFG4: reg_rdata = cfg4_q;
      default: reg_rdata = `DDSF_ERASED;
    endcase
  end

  // protected size is 2^(19+bp) bytes of this die, none of it for bp=0, all of it for bp=7
  assign bp = status_q[`DDSF_BP_HI:`DDSF_BP_LO];
  assign shamt = 5'd`DDSF_PROT_BASE + {2'b00, bp};
  assign mask = (26'h1 << shamt) - 26'h1;
  assign prot = (bp == 3'h0) ? 1'b0 :
                (bp == 3'h7) ? 1'b1 :
                cfg1_q[`DDSF_ORIENT_BIT] ? ((offset & ~mask) == 26'h0) :
                ((offset | mask) == {26{1'b1}});
  assign latch = latch_q;
  assign status_q_out = status_q;
  assign cfg1_out = cfg1_q;
  assign cfg2_out = cfg2_q;
  assign cfg3_out = cfg3_q;
  assign cfg4_out = cfg4_q;
endmodule // ddsf_die

// ### hdl/ddsf_router.v
// two-die serial flash front end: link decode, die routing, bus slave
//
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "ddsf_consts.vh"
module ddsf_router (
  // clock, reset, enable
  input wire aclk,
  input wire aresetn,
  input wire ce,
  // serial link pins
  input wire spi_sclk,
  input wire spi_cs_n,
  input wire spi_mosi,
  output reg spi_miso,
  output wire spi_miso_oe,
  // axi4-lite write
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  localparam ST_IDLE = 3'd0;
  localparam ST_OP = 3'd1;
  localparam ST_ADDR = 3'd2;
  localparam ST_DIN = 3'd3;
  localparam ST_DOUT = 3'd4;
  localparam ST_IGN = 3'd5;

  reg sclk_s1, sclk_s2, sclk_s3;
  reg cs_s1, cs_s2;
  reg mosi_s1, mosi_s2;
  reg [2:0] st_q;
  reg [2:0] bitcnt_q;
  reg [6:0] sh_q;
  reg [7:0] op_q;
  reg [31:0] addr_q;
  reg [1:0] left_q;
  reg [26:0] ptr_q;
  reg [6:0] out_q;
  reg [7:0] wdata_q;
  reg got_q;
  reg addr_done_q;
  reg wide_q;
  reg link_en_q;
  reg unsup_q;
  reg rej_q;
  reg [7:0] unsup_cnt_q;
  reg [7:0] wr_cnt_q;
  reg latch_set_q;
  reg latch_clr_q;
  reg [1:0] wdone_q;
  reg [1:0] rwr_q;

  wire rise;
  wire fall;
  wire [7:0] byte_in;
  wire unsup_op;
  wire is_read;
  wire is_write;
  wire is_rread;
  wire four_only;
  wire die_sel;
  wire [1:0] latch_w;
  wire [1:0] prot_w;
  wire [7:0] rdat_w [0:1];
  wire [7:0] st_w [0:1];
  wire [7:0] c1_w [0:1];
  wire [7:0] c2_w [0:1];
  wire [7:0] c3_w [0:1];
  wire [7:0] c4_w [0:1];
  wire [7:0] next_byte;
  wire clr_req;
  wire wr_take;

  // two flops on every pin; third sclk flop only feeds the edge finder
  always @(posedge aclk) begin
    if (!aresetn) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
    end else if (ce) begin
      sclk_s1 <= spi_sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      cs_s1 <= spi_cs_n;
      cs_s2 <= cs_s1;
      mosi_s1 <= spi_mosi;
      mosi_s2 <= mosi_s1;
    end
  end

  assign rise = sclk_s2 & ~sclk_s3;
  assign fall = ~sclk_s2 & sclk_s3;
  assign byte_in = {sh_q, mosi_s2};
  // legacy commands without address cannot be steered to a die
  assign unsup_op = (byte_in == `DDSF_OP_U01) || (byte_in == `DDSF_OP_U35) ||
                    (byte_in == `DDSF_OP_U05) ||
                    (byte_in == `DDSF_OP_U07) || (byte_in == `DDSF_OP_U43) ||
                    (byte_in == `DDSF_OP_U2F) ||
                    (byte_in == `DDSF_OP_UE8) || (byte_in == `DDSF_OP_UE4) ||
                    (byte_in == `DDSF_OP_UB0) ||
                    (byte_in == `DDSF_OP_U30);
  assign is_read = (op_q == `DDSF_OP_READ3) || (op_q == `DDSF_OP_READ4);
  assign is_rread = (op_q == `DDSF_OP_RREAD);
  assign is_write = (op_q == `DDSF_OP_PP3) || (op_q == `DDSF_OP_PP4) ||
                    (op_q == `DDSF_OP_SE3) || (op_q == `DDSF_OP_SE4);
  assign four_only = (byte_in == `DDSF_OP_READ4) ||
                     (byte_in == `DDSF_OP_PP4) || (byte_in == `DDSF_OP_SE4);
  assign die_sel = addr_q[`DDSF_DIE_BIT];
  // erased array reads ones; register read repeats the addressed register
  assign next_byte = is_rread ? rdat_w[ptr_q[`DDSF_DIE_BIT]] :
                     `DDSF_ERASED;
  assign spi_miso_oe = ~cs_s2 & (st_q == ST_DOUT);

  // command framing, address collection and read pointer
  always @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_IDLE;
      bitcnt_q <= 3'h0;
      sh_q <= 7'h00;
      op_q <= 8'h00;
      addr_q <= 32'h0;
      left_q <= 2'h0;
      ptr_q <= 27'h0;
      out_q <= 7'h00;
      wdata_q <= 8'h00;
      got_q <= 1'b0;
      addr_done_q <= 1'b0;
      wide_q <= 1'b0;
      spi_miso <= 1'b0;
      latch_set_q <= 1'b0;
      latch_clr_q <= 1'b0;
      wdone_q <= 2'b00;
      rwr_q <= 2'b00;
      rej_q <= 1'b0;
      wr_cnt_q <= 8'h00;
    end else if (ce) begin
      latch_set_q <= 1'b0;
      latch_clr_q <= 1'b0;
      wdone_q <= 2'b00;
      rwr_q <= 2'b00;
      if (cs_s2) begin
        // frame end commits register writes and program or erase
        if (st_q != ST_IDLE && addr_done_q) begin
          if (op_q == `DDSF_OP_RWRITE && got_q && latch_w[die_sel]) begin
            rwr_q[die_sel] <= 1'b1;
            wdone_q[die_sel] <= 1'b1;
          end
          if (is_write) begin
            if (latch_w[die_sel] && !prot_w[die_sel]) begin
              wr_cnt_q <= wr_cnt_q + 8'h01;
              rej_q <= 1'b0;
            end else begin
              rej_q <= 1'b1;
            end
            if (latch_w[die_sel]) begin
              wdone_q[die_sel] <= 1'b1;
            end
          end
        end
        st_q <= ST_IDLE;
        addr_done_q <= 1'b0;
      end else if (st_q == ST_IDLE) begin
        // both dies see the one select, so one decoder serves them
        if (link_en_q) begin
          st_q <= ST_OP;
        end else begin
          st_q <= ST_IGN;
        end
        bitcnt_q <= 3'h0;
        addr_q <= 32'h0;
        got_q <= 1'b0;
      end else if (rise) begin
        sh_q <= byte_in[6:0];
        bitcnt_q <= bitcnt_q + 3'h1;
        if (bitcnt_q == 3'h7) begin
          case (st_q)
            ST_OP: begin
              op_q <= byte_in;
              left_q <= (wide_q || four_only) ? 2'h3 : 2'h2;
              if (unsup_op) begin
                st_q <= ST_IGN;
              end else if (byte_in == `DDSF_OP_WRITE_LATCH_SET_CMD) begin
                latch_set_q <= 1'b1;
                st_q <= ST_IGN;
              end else if (byte_in == `DDSF_OP_WRDI) begin
                latch_clr_q <= 1'b1;
                st_q <= ST_IGN;
              end else if (byte_in == `DDSF_OP_WIDE) begin
                wide_q <= 1'b1;
                st_q <= ST_IGN;
              end else if (byte_in == `DDSF_OP_READ3 ||
                           byte_in == `DDSF_OP_READ4 ||
                           byte_in == `DDSF_OP_PP3 ||
                           byte_in == `DDSF_OP_PP4 ||
                           byte_in == `DDSF_OP_SE3 ||
                           byte_in == `DDSF_OP_SE4 ||
                           byte_in == `DDSF_OP_RREAD ||
                           byte_in == `DDSF_OP_RWRITE) begin
                st_q <= ST_ADDR;
              end else begin
                st_q <= ST_IGN;
              end
            end
            ST_ADDR: begin
              addr_q <= {addr_q[23:0], byte_in};
              left_q <= left_q - 2'h1;
              if (left_q == 2'h0) begin
                addr_done_q <= 1'b1;
                ptr_q <= {addr_q[18:0], byte_in};
                st_q <= (is_read || is_rread) ? ST_DOUT : ST_DIN;
              end
            end
            ST_DIN: begin
              if (!got_q) begin
                wdata_q <= byte_in;
                got_q <= 1'b1;
              end
            end
            default: ;
          endcase
        end
      end else if (fall && st_q == ST_DOUT) begin
        if (bitcnt_q == 3'h0) begin
          spi_miso <= next_byte[7];
          out_q <= next_byte[6:0];
          // pointer wraps inside the die holding it
          if (is_read) begin
            ptr_q <= {ptr_q[`DDSF_DIE_BIT], ptr_q[25:0] + 26'h1};
          end
        end else begin
          spi_miso <= out_q[6];
          out_q <= {out_q[5:0], 1'b0};
        end
      end
    end
  end

  // one instance per die, both fed the same strobes except own write done and register write
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_die
      ddsf_die u_die (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .latch_set(latch_set_q),
        .latch_clr_all(latch_clr_q),
        .write_done(wdone_q[gi]),
        .reg_wr(rwr_q[gi]),
        .reg_idx(addr_q[2:0]),
        .reg_wdata(wdata_q),
        .offset(addr_q[25:0]),
        .latch(latch_w[gi]),
        .prot(prot_w[gi]),
        .reg_rdata(rdat_w[gi]),
        .status_q_out(st_w[gi]),
        .cfg1_out(c1_w[gi]),
        .cfg2_out(c2_w[gi]),
        .cfg3_out(c3_w[gi]),
        .cfg4_out(c4_w[gi])
      );
    end
  endgenerate

  // write side: address and data taken together, one response at a time
  assign wr_take = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wr_take;
  assign s_axi_wready = wr_take;
  assign clr_req = wr_take && s_axi_awaddr == `DDSF_A_CTRL &&
                   s_axi_wstrb[0] && s_axi_wdata[1];

  // control register and unsupported-command bookkeeping
  always @(posedge aclk) begin
    if (!aresetn) begin
      link_en_q <= 1'b1;
      unsup_q <= 1'b0;
      unsup_cnt_q <= 8'h00;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DDSF_RESP_OK;
    end else if (ce) begin
      if (wr_take) begin
        s_axi_bvalid <= 1'b1;
        if (s_axi_awaddr == `DDSF_A_CTRL) begin
          s_axi_bresp <= `DDSF_RESP_OK;
          if (s_axi_wstrb[0]) begin
            link_en_q <= s_axi_wdata[0];
          end
        end else if (s_axi_awaddr[7:2] <= `DDSF_A_CFG4 >> 2 &&
                     s_axi_awaddr[1:0] == 2'b00) begin
          s_axi_bresp <= `DDSF_RESP_OK; // read-only, write dropped
        end else begin
          s_axi_bresp <= `DDSF_RESP_ERR;
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // new refusal wins over a clear in the same cycle
      if (!cs_s2 && rise && st_q == ST_OP && bitcnt_q == 3'h7 && unsup_op) begin
        unsup_q <= 1'b1;
        unsup_cnt_q <= unsup_cnt_q + 8'h01;
      end else if (clr_req) begin
        unsup_q <= 1'b0;
        unsup_cnt_q <= 8'h00;
      end
    end
  end

  // read side: one beat in flight, arready low while it waits
  assign s_axi_arready = ~s_axi_rvalid;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `DDSF_RESP_OK;
    end else if (ce) begin
      if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `DDSF_RESP_OK;
        case (s_axi_araddr)
          `DDSF_A_CTRL: s_axi_rdata <= {31'h0, link_en_q};
          `DDSF_A_STATUS: s_axi_rdata <= {25'h0, rej_q, die_sel,
                                          ~cs_s2, unsup_q, latch_w,
                                          wide_q};
          `DDSF_A_COUNT: s_axi_rdata <= {16'h0, wr_cnt_q, unsup_cnt_q};
          `DDSF_A_PTR: s_axi_rdata <= {5'h00, ptr_q};
          `DDSF_A_MAP: s_axi_rdata <= `DDSF_MAP_WORD;
          `DDSF_A_PROT: s_axi_rdata <= {`DDSF_RST_PROT,
                                        `DDSF_RST_PROT};
          `DDSF_A_DIE0: s_axi_rdata <= {c3_w[0], c2_w[0], c1_w[0], st_w[0]};
          `DDSF_A_DIE1: s_axi_rdata <= {c3_w[1], c2_w[1], c1_w[1], st_w[1]};
          `DDSF_A_CFG4: s_axi_rdata <= {8'h00, c4_w[1], 8'h00, c4_w[0]};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `DDSF_RESP_ERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // ddsf_router

// ### tb/ddsf_spi_host.sv
// behavioural serial host that drives the shared select and link clock
`timescale 1ns/100ps
module ddsf_spi_host (
  // link pins driven by the host
  output reg spi_sclk,
  output reg spi_cs_n,
  output reg spi_mosi,
  // read-back pins from the package
  input wire spi_miso,
  input wire spi_miso_oe
);
  reg last_q;
  reg oe_seen_q;
  reg [15:0] rx_q;

  // link clock stands still low between frames
  initial begin
    spi_sclk = 1'h0;
    spi_cs_n = 1'h1;
    spi_mosi = 1'h0;
    last_q = 1'h0;
    oe_seen_q = 1'h0;
    rx_q = 16'h0000;
  end

  // mode 0 byte, msb first; a released line shows the inverse of its last bit
  task xfer(input [7:0] tx);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        spi_mosi = tx[i];
        #400 spi_sclk = 1'h1;
        last_q = spi_miso_oe ? spi_miso : ~last_q;
        oe_seen_q = oe_seen_q | spi_miso_oe;
        rx_q = {rx_q[14:0], last_q};
        #400 spi_sclk = 1'h0;
      end
    end
  endtask

  // odd offset keeps link edges off the bus clock edges
  task start(input [7:0] op);
    begin
      #37 oe_seen_q = 1'h0;
      spi_cs_n = 1'h0;
      #400 xfer(op);
    end
  endtask

  // deselect gap is far above the minimum so the sync stages settle
  task stop;
    begin
      #400 spi_cs_n = 1'h1;
      spi_mosi = ~spi_mosi;
      #1200;
    end
  endtask
endmodule // ddsf_spi_host

// ### tb/ddsf_router_checker.sv
// concurrent checks on the router's bus and link ports
`timescale 1ns/100ps
`include "ddsf_consts.vh"
module ddsf_router_checker (
  // clock, reset, enable
  input wire aclk,
  input wire aresetn,
  input wire ce,
  // link
  input wire spi_cs_n,
  input wire spi_miso_oe,
  // write channels
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  // read channels
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  // a frozen enable stalls all state, so the checks pause with it
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);
  wire ar_take = s_axi_arvalid && s_axi_arready;

  AST_MAP_WORD:
  assert property (ar_take && s_axi_araddr == `DDSF_A_MAP
    |=> s_axi_rdata == `DDSF_MAP_WORD) else $error("map word wrong");
  AST_PROT_CFG:
  assert property (ar_take && s_axi_araddr == `DDSF_A_PROT
    |=> s_axi_rdata == 32'hFFFFFFFF) else $error("protect config wrong");
  AST_OE_SELECT:
  assert property (spi_cs_n [*4] |-> !spi_miso_oe)
    else $error("miso driven while deselected");
  AST_B_AFTER_AW:
  assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready
    |=> s_axi_bvalid) else $error("write answer late");
  AST_B_HOLD:
  assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  AST_R_AFTER_AR:
  assert property (ar_take |=> s_axi_rvalid) else $error("read answer late");
  AST_R_HOLD:
  assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped");
  AST_AR_BLOCK:
  assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  AST_W_PAIR:
  assert property (s_axi_awready |-> s_axi_wready && s_axi_awvalid
    && s_axi_wvalid && !s_axi_bvalid) else $error("write ready unpaired");
  AST_UNMAPPED:
  assert property (ar_take && (s_axi_araddr > 8'h20
    || s_axi_araddr[1:0] != 2'h0) |=> s_axi_rresp == `DDSF_RESP_ERR
    && s_axi_rdata == 32'h00000000) else $error("unmapped read wrong");
endmodule // ddsf_router_checker

bind ddsf_router ddsf_router_checker u_chk (.aclk(aclk), .aresetn(aresetn),
  .ce(ce), .spi_cs_n(spi_cs_n), .spi_miso_oe(spi_miso_oe),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ### tb/ddsf_router_tb.sv
// self-checking bench for the two-die flash router
`timescale 1ns/100ps
`include "ddsf_consts.vh"
module ddsf_router_tb;
  reg aclk, aresetn, ce;
  wire spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  reg [7:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata, rd;
  reg [3:0] s_axi_wstrb;
  reg s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  reg [1:0] rs;
  integer mismatches, checks_done, wr_n;

  ddsf_router u_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  ddsf_spi_host u_host (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));

  // 10 MHz bus clock
  initial aclk = 1'h0;
  always #50 aclk = ~aclk;

  task cmp(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  // ready is raised late on purpose so the slave must hold its answer
  task axi_wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      do @(posedge aclk); while (s_axi_awready !== 1'h1);
      s_axi_awvalid <= 1'h0;
      s_axi_wvalid <= 1'h0;
      do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h1;
      do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
      rs = s_axi_bresp;
      s_axi_bready <= 1'h0;
    end
  endtask
  task axi_rd(input [7:0] a);
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      do @(posedge aclk); while (s_axi_arready !== 1'h1);
      s_axi_arvalid <= 1'h0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
      s_axi_rready <= 1'h1;
      do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'h0;
    end
  endtask
  task rd_chk(input [7:0] a, input [31:0] exp);
    begin
      axi_rd(a);
      cmp(rd, exp);
    end
  endtask
  // one frame: opcode, na address bytes msb first, nb data bytes of d
  // no key, protection config or suspend programs are ever sent
  task frm(input [7:0] op, input integer na, input [31:0] a,
    input integer nb, input [7:0] d);
    integer i;
    begin
      u_host.start(op);
      for (i = na - 1; i >= 0; i = i - 1) u_host.xfer(a[i*8 +: 8]);
      for (i = 0; i < nb; i = i + 1) u_host.xfer(d);
      u_host.stop;
    end
  endtask

  task t_deliver;
    begin
      rd_chk(`DDSF_A_MAP, `DDSF_MAP_WORD);
      rd_chk(`DDSF_A_PROT, 32'hFFFFFFFF);
      rd_chk(`DDSF_A_DIE0, 32'h00080000);
      rd_chk(`DDSF_A_DIE1, 32'h00080000);
      rd_chk(`DDSF_A_CFG4, 32'h00000000);
      rd_chk(`DDSF_A_STATUS, 32'h00000000);
      rd_chk(8'h24, 32'h00000000);
      cmp(rs, `DDSF_RESP_ERR);
      axi_wr(8'h26, 32'h00000000);
      cmp(rs, `DDSF_RESP_ERR);
      $display("test deliver done");
    end
  endtask
  task t_unsup;
    reg [79:0] ops;
    integer k;
    begin
      ops = {80'h0135050743_2FE8E4B030};
      for (k = 0; k < 10; k = k + 1) begin
        frm(ops[79-8*k -: 8], 4, 32'h00000000, 1, 8'h00);
        cmp(u_host.oe_seen_q, 32'h0);
        axi_rd(`DDSF_A_COUNT);
        cmp(rd[7:0], k + 1);
      end
      axi_rd(`DDSF_A_STATUS);
      cmp(rd[3], 32'h1);
      axi_wr(`DDSF_A_CTRL, 32'h00000003);
      cmp(rs, `DDSF_RESP_OK);
      rd_chk(`DDSF_A_COUNT, 32'h00000000);
      $display("test unsupported done");
    end
  endtask
  task t_wide;
    begin
      frm(8'hB7, 0, 32'h0, 0, 8'h00);
      axi_rd(`DDSF_A_STATUS);
      cmp(rd[0], 32'h1);
      frm(8'h65, 4, 32'h00000003, 1, 8'h00);
      cmp(u_host.rx_q[7:0], 8'h08);
      $display("test wide done");
    end
  endtask
  // pointer ends three past the start: one byte after the last is preloaded
  task t_wrap;
    begin
      frm(8'h03, 4, 32'h03FFFFFF, 2, 8'h00);
      cmp(u_host.rx_q, 16'hFFFF);
      axi_rd(`DDSF_A_PTR);
      cmp(rd, 32'h00000002);
      frm(8'h13, 4, 32'h07FFFFFF, 2, 8'h00);
      cmp(u_host.rx_q, 16'hFFFF);
      axi_rd(`DDSF_A_PTR);
      cmp(rd, 32'h04000002);
      $display("test wrap done");
    end
  endtask
  task t_latch;
    begin
      frm(8'h06, 0, 32'h0, 0, 8'h00);
      axi_rd(`DDSF_A_STATUS);
      cmp(rd[2:1], 32'h3);
      frm(8'h02, 4, 32'h04000000, 1, 8'hA5);
      wr_n = wr_n + 1;
      axi_rd(`DDSF_A_STATUS);
      cmp(rd[5:1], 32'h11);
      rd_chk(`DDSF_A_COUNT, wr_n << 8);
      frm(8'h04, 0, 32'h0, 0, 8'h00);
      axi_rd(`DDSF_A_STATUS);
      cmp(rd[2:1], 32'h0);
      axi_wr(`DDSF_A_CTRL, 32'h00000000);
      frm(8'h06, 0, 32'h0, 0, 8'h00);
      axi_rd(`DDSF_A_STATUS);
      cmp(rd[2:1], 32'h0);
      axi_wr(`DDSF_A_CTRL, 32'h00000001);
      $display("test latch done");
    end
  endtask
  // whole upper die protected must not block the lower die
  task t_prot;
    begin
      frm(8'h06, 0, 32'h0, 0, 8'h00);
      frm(8'h71, 4, 32'h04000000, 1, 8'h1C);
      rd_chk(`DDSF_A_DIE1, 32'h0008001C);
      rd_chk(`DDSF_A_DIE0, 32'h00080000);
      rd_chk(`DDSF_A_CFG4, 32'h00000000);
      frm(8'h65, 4, 32'h04000000, 1, 8'h00);
      cmp(u_host.rx_q[7:0], 8'h1C);
      frm(8'h06, 0, 32'h0, 0, 8'h00);
      frm(8'hDC, 4, 32'h04000000, 0, 8'h00);
      axi_rd(`DDSF_A_STATUS);
      cmp(rd[6], 32'h1);
      rd_chk(`DDSF_A_COUNT, wr_n << 8);
      frm(8'h12, 4, 32'h00000100, 0, 8'h00);
      wr_n = wr_n + 1;
      rd_chk(`DDSF_A_COUNT, wr_n << 8);
      $display("test protect done");
    end
  endtask

  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask

  // main sequence; frames wait four cycles for the select synchroniser
  initial begin
    mismatches = 0;
    checks_done = 0;
    wr_n = 0;
    ce = 1'h1;
    aresetn = 1'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (4) @(posedge aclk);
    t_deliver;
    t_unsup;
    t_wide;
    t_wrap;
    t_latch;
    t_prot;
    print_verdict;
  end
  // 24 frames of up to seven 6.4 us bytes each; 5 ms leaves ample margin
  initial begin
    #5000000;
    mismatches = mismatches + 1;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict;
  end
endmodule // ddsf_router_tb
